/* hdl/lcs_clock_cfg.sv */
// LCD clock source selection and configuration command decoding
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "lcs_defines.svh"
module lcs_clock_cfg
  import lcs_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // Device reset pin, active low
  input wire logic I_RESET_N,
  // Avalon-MM slave
  input wire logic [`LCS_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Shared clock pin, three signals
  input wire logic I_SHARED_CLOCK_PIN,
  output logic O_SHARED_CLOCK_PIN,
  output logic O_SHARED_CLOCK_PIN_OE,
  // Timing outputs
  output logic O_OSC_RUN,
  output logic O_LCD_FRAME_TICK,
  output logic O_PWM_CLK_TICK,
  // Decoded configuration
  output logic [11:0] O_PIN_MODE_FIELD,
  output logic [1:0] O_MUX_MODE,
  output logic [1:0] O_BIAS_MODE
);

  localparam int OSC_DIV = `LCS_CLK_HZ / `LCS_OSC_HZ;

  generate
    if (OSC_DIV < 2 || OSC_DIV > 255) begin : g_bad_osc
      $error("lcs_clock_cfg: oscillator divisor out of range");
    end
  endgenerate

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] rst_sync;
  logic [2:0] clk_sync;
  logic pin_rst;
  logic ext_level;
  logic ext_prev;

  // A change counts only when the second and third stages agree
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      rst_sync <= 3'h0;
      clk_sync <= 3'h0;
      pin_rst <= 1'b1;
      ext_level <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      rst_sync <= {rst_sync[1:0], I_RESET_N};
      clk_sync <= {clk_sync[1:0], I_SHARED_CLOCK_PIN};
      if (rst_sync[1] == rst_sync[2]) pin_rst <= ~rst_sync[2];
      if (clk_sync[1] == clk_sync[2]) ext_level <= clk_sync[2];
      ext_prev <= ext_level;
    end
  end

  wire logic ext_edge = ext_level & ~ext_prev;
  wire logic any_rst = I_SYS_RST | pin_rst;

  // ****************************************************************
  // Avalon slave: one wait cycle per access
  // ****************************************************************
  logic ack;
  logic pd;
  lcs_cfg_t cfg;
  logic [31:0] next_readdata;

  wire logic req = I_AVS_READ | I_AVS_WRITE;
  wire logic acc_wr = I_AVS_WRITE & ack;
  wire logic sel_cmd = I_AVS_ADDRESS == `LCS_REG_CMD;
  wire logic sel_ctrl = I_AVS_ADDRESS == `LCS_REG_CTRL;
  wire logic sel_stat = I_AVS_ADDRESS == `LCS_REG_STATUS;
  wire logic wr_cmd = acc_wr & sel_cmd & I_AVS_BYTEENABLE[0];
  wire logic wr_ctrl = acc_wr & sel_ctrl & I_AVS_BYTEENABLE[0];

  assign O_AVS_WAITREQUEST = req & ~ack;

  // Status word shows live state; unmapped words read zero
  assign next_readdata = sel_stat ?
    {5'h00, O_SHARED_CLOCK_PIN_OE, O_OSC_RUN, pd, cfg} :
    sel_ctrl ? {31'h0000_0000, pd} : `LCS_ZERO_WORD;

  // Read data is caught on the wait cycle and stands on the answer
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      ack <= 1'b0;
      O_AVS_READDATA <= `LCS_ZERO_WORD;
    end else begin
      ack <= req & ~ack;
      if (I_AVS_READ & ~ack) O_AVS_READDATA <= next_readdata;
    end
  end

  // Power-down control bit
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      pd <= 1'b0;
    end else if (wr_ctrl) begin
      pd <= I_AVS_WRITEDATA[`LCS_CTRL_PD_BIT];
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire logic [7:0] cmd = I_AVS_WRITEDATA[7:0];
  wire logic hit_mux = cmd[7:2] == `LCS_PFX_MUX;
  wire logic hit_bias = cmd[7:2] == `LCS_PFX_BIAS;
  wire logic hit_osc = cmd[7:3] == `LCS_PFX_OSC;
  wire logic hit_fd = cmd[7:5] == `LCS_PFX_FD;
  logic [`LCS_GPM_PAIRS-1:0] hit_gpm;
  logic [11:0] next_pin_mode;
  logic [`LCS_PIN_COUNT-1:0] pin_pwm;
  lcs_cfg_t next_cfg;

  // One command byte per pin pair; low field is the even pin
  genvar g;
  generate
    for (g = 0; g < `LCS_GPM_PAIRS; g++) begin : g_pair
      assign hit_gpm[g] = cmd[7:4] == (`LCS_PFX_GPM_BASE + 4'(g));
      assign next_pin_mode[g*4 +: 4] = (wr_cmd & hit_gpm[g]) ?
        cmd[3:0] : cfg.pin_mode_field[g*4 +: 4];
    end
    for (g = 0; g < `LCS_PIN_COUNT; g++) begin : g_pin
      assign pin_pwm[g] = cfg.pin_mode_field[g*2 +: 2] == `LCS_MODE_PWM;
    end
  endgenerate

  wire logic pwm_en = |pin_pwm;

  // Fields not addressed by the byte keep their value
  always_comb begin
    next_cfg = cfg;
    next_cfg.pin_mode_field = next_pin_mode;
    if (wr_cmd) begin
      if (hit_mux) next_cfg.mux_mode = cmd[1:0];
      if (hit_bias) next_cfg.bias_mode = cmd[1:0];
      if (hit_fd) next_cfg.lcd_frame_prescaler = cmd[4:0];
      if (hit_osc) begin
        next_cfg.ext_freq_range = cmd[`LCS_OSC_EFR_BIT];
        next_cfg.clock_out_enable = cmd[`LCS_OSC_COE_BIT];
        next_cfg.osc_source = cmd[`LCS_OSC_SRC_BIT];
      end
    end
  end

  // Either reset forces defaults before a command can land
  always_ff @(posedge I_CLOCK) begin
    if (any_rst) begin
      cfg <= LCS_CFG_DEFAULT;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign O_PIN_MODE_FIELD = cfg.pin_mode_field;
  assign O_MUX_MODE = cfg.mux_mode;
  assign O_BIAS_MODE = cfg.bias_mode;

  // ****************************************************************
  // Prescaler lookup
  // ****************************************************************
  // Codes above the table fall back to the fastest frame rate
  function automatic logic [`LCS_Q_W-1:0] q_of(input logic [4:0] fd);
    case (fd)
      5'h00: q_of = 7'h50;
      5'h01: q_of = 7'h44;
      5'h02: q_of = 7'h3C;
      5'h03: q_of = 7'h35;
      5'h04: q_of = 7'h30;
      5'h05: q_of = 7'h2C;
      5'h06: q_of = 7'h28;
      5'h07: q_of = 7'h25;
      5'h08: q_of = 7'h22;
      5'h09: q_of = 7'h20;
      5'h0A: q_of = 7'h1E;
      5'h0B: q_of = 7'h1C;
      5'h0C: q_of = 7'h1B;
      5'h0D: q_of = 7'h19;
      5'h0E: q_of = 7'h18;
      5'h0F: q_of = 7'h17;
      5'h10: q_of = 7'h16;
      5'h11: q_of = 7'h15;
      5'h12: q_of = 7'h14;
      5'h13: q_of = 7'h13;
      5'h14: q_of = 7'h12;
      5'h15: q_of = 7'h11;
      default: q_of = 7'h10;
    endcase
  endfunction : q_of

  // ****************************************************************
  // Clock source and dividers
  // ****************************************************************
  wire logic ext_src = cfg.osc_source;
  wire logic ext_slow = ext_src & ~cfg.ext_freq_range;
  // PWM needs the fast clock, so a slow external clock wakes the osc
  wire logic next_osc_run = ~pin_rst & ~pd &
    (~ext_src | (pwm_en & ~cfg.ext_freq_range));
  logic osc_tick;
  logic inter_tick;
  logic inter_level;
  logic frame_tick;

  lcs_tick_div #(.W(`LCS_OSC_W)) u_osc (
    .i_clk(I_CLOCK),
    .i_clear(any_rst | ~O_OSC_RUN),
    .i_tick(1'b1),
    .i_div(`LCS_OSC_W'(OSC_DIV)),
    .o_tick(osc_tick),
    .o_level()
  );

  wire logic lcd_src_tick = ext_src ? ext_edge : osc_tick;

  lcs_tick_div #(.W(`LCS_Q_W)) u_inter (
    .i_clk(I_CLOCK),
    .i_clear(any_rst),
    .i_tick(lcd_src_tick),
    .i_div(q_of(cfg.lcd_frame_prescaler)),
    .o_tick(inter_tick),
    .o_level(inter_level)
  );

  wire logic frame_in = ext_slow ? ext_edge : inter_tick;

  lcs_tick_div #(.W(`LCS_FRAME_W)) u_frame (
    .i_clk(I_CLOCK),
    .i_clear(any_rst),
    .i_tick(frame_in),
    .i_div(`LCS_FRAME_DIV),
    .o_tick(frame_tick),
    .o_level()
  );

  assign O_LCD_FRAME_TICK = frame_tick;

  // Pin drive: floats unless enabled with the internal source
  wire logic next_pin_oe = ~pin_rst & ~ext_src &
    cfg.clock_out_enable;
  wire logic next_pin_out = pd | inter_level;
  wire logic next_pwm_tick = (ext_src & cfg.ext_freq_range) ?
    ext_edge : osc_tick;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_OSC_RUN <= 1'b0;
      O_SHARED_CLOCK_PIN_OE <= 1'b0;
      O_SHARED_CLOCK_PIN <= 1'b0;
      O_PWM_CLK_TICK <= 1'b0;
    end else begin
      O_OSC_RUN <= next_osc_run;
      O_SHARED_CLOCK_PIN_OE <= next_pin_oe;
      O_SHARED_CLOCK_PIN <= next_pin_out;
      O_PWM_CLK_TICK <= next_pwm_tick;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_req_wait;
    req && O_AVS_WAITREQUEST;
  endsequence

  sequence s_req_done;
    !O_AVS_WAITREQUEST || !req;
  endsequence

  bus_answer_a: assert property (s_req_wait |=> s_req_done)
    else $error("bus access not answered after one wait cycle");

  osc_reset_off_a: assert property (pin_rst |=> !O_OSC_RUN)
    else $error("oscillator running during pin reset");

  pin_reset_hiz_a: assert property (pin_rst |=> !O_SHARED_CLOCK_PIN_OE)
    else $error("clock pin driven during pin reset");

  ext_pin_input_a: assert property (cfg.osc_source |=> !O_SHARED_CLOCK_PIN_OE)
    else $error("clock pin driven with external source");

  osc_ext_off_a: assert property (
    (cfg.osc_source && !(pwm_en && !cfg.ext_freq_range)) |=> !O_OSC_RUN)
    else $error("oscillator running with external source");

  osc_int_on_a: assert property (
    (!cfg.osc_source && !pd && !pin_rst) |=> O_OSC_RUN)
    else $error("internal oscillator not running in power-up");

  pin_clock_out_a: assert property (
    (!pin_rst && !cfg.osc_source && cfg.clock_out_enable && !pd) |=>
    (O_SHARED_CLOCK_PIN_OE && O_SHARED_CLOCK_PIN == $past(inter_level)))
    else $error("clock pin not showing the intermediate clock");

  mux_decode_a: assert property (
    (wr_cmd && hit_mux && !pin_rst) |=> cfg.mux_mode == $past(cmd[1:0]))
    else $error("multiplex command not taken");

  unknown_cmd_a: assert property (
    (wr_cmd && !pin_rst && !hit_mux && !hit_bias && !hit_osc && !hit_fd &&
     hit_gpm == 3'h0) |=> $stable(cfg))
    else $error("unknown command changed configuration");

  cfg_default_a: assert property (pin_rst |=> cfg == LCS_CFG_DEFAULT)
    else $error("configuration not at default after reset");

endmodule : lcs_clock_cfg

/* hdl/lcs_defines.svh */
// Constants for the LCD clock source and configuration block
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

// ****************************************************************
// Clock rates
// ****************************************************************
`define LCS_CLK_HZ 40_000_000
`define LCS_OSC_HZ 230_000

// ****************************************************************
// Register word indexes on the Avalon slave
// ****************************************************************
`define LCS_ADDR_W 2
`define LCS_REG_CMD 2'h0
`define LCS_REG_CTRL 2'h1
`define LCS_REG_STATUS 2'h2
`define LCS_CTRL_PD_BIT 0
`define LCS_ZERO_WORD 32'h0000_0000

// ****************************************************************
// Command prefixes
// ****************************************************************
`define LCS_PFX_MUX 6'h00
`define LCS_PFX_BIAS 6'h01
`define LCS_PFX_OSC 5'h03
`define LCS_PFX_FD 3'h1
`define LCS_PFX_GPM_BASE 4'hC
`define LCS_GPM_PAIRS 3
`define LCS_PIN_COUNT 6
`define LCS_OSC_EFR_BIT 2
`define LCS_OSC_COE_BIT 1
`define LCS_OSC_SRC_BIT 0

// ****************************************************************
// Modes, defaults and divide factors
// ****************************************************************
`define LCS_MODE_PWM 2'h3
`define LCS_FD_DEFAULT 5'h0E
`define LCS_FRAME_DIV 6'h30
`define LCS_Q_W 7
`define LCS_FRAME_W 6
`define LCS_OSC_W 8

`endif

/* hdl/lcs_pkg.sv */
// Types shared by the LCD clock source and configuration block
package lcs_pkg;

  // Configuration fields written by commands
  typedef struct packed {
    logic [11:0] pin_mode_field;
    logic [1:0] mux_mode;
    logic [1:0] bias_mode;
    logic [4:0] lcd_frame_prescaler;
    logic ext_freq_range;
    logic clock_out_enable;
    logic osc_source;
  } lcs_cfg_t;

  localparam lcs_cfg_t LCS_CFG_DEFAULT = '{
    pin_mode_field: 12'h000,
    mux_mode: 2'h0,
    bias_mode: 2'h0,
    lcd_frame_prescaler: 5'h0E,
    ext_freq_range: 1'b0,
    clock_out_enable: 1'b0,
    osc_source: 1'b0
  };

endpackage : lcs_pkg

/* hdl/lcs_tick_div.sv */
// Tick divider with a duty level, used for oscillator, prescaler, frame
`timescale 1ns/1ps
module lcs_tick_div
  import lcs_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and clear
  input wire logic i_clk,
  input wire logic i_clear,
  // Input tick and divisor
  input wire logic i_tick,
  input wire logic [W-1:0] i_div,
  // Divided outputs
  output logic o_tick,
  output logic o_level
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  generate
    if (W < 2) begin : g_bad_width
      $error("lcs_tick_div: width below 2");
    end
  endgenerate

  logic [W-1:0] count;
  wire logic at_last = (count + W'(1)) >= i_div;
  wire logic low_half = count < (i_div >> 1);

  // Duty follows the divisor, so odd ratios are not half high
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      count <= '0;
      o_tick <= 1'b0;
      o_level <= 1'b0;
    end else begin
      o_tick <= i_tick & at_last;
      o_level <= low_half;
      if (i_tick) begin
        count <= at_last ? '0 : count + W'(1);
      end
    end
  end

endmodule : lcs_tick_div

/* tb/lcs_ext_clk_src.sv */
// External clock source model for the shared clock pin
`timescale 1ns/1ps
module lcs_ext_clk_src
  import lcs_pkg::*;
#(
  parameter real HALF_NS = 250.0
) (
  // Control from the bench
  input wire logic i_enable,
  // Pin drive
  output logic o_drive,
  output logic o_level
);
  // Free-running while enabled, phase unrelated to the system clock
  initial begin
    o_level = 1'b0;
    #7.3;
    forever begin
      #(HALF_NS);
      o_level = i_enable ? ~o_level : 1'b0;
    end
  end

  // Released when disabled; the pin may then float
  assign o_drive = i_enable;
endmodule : lcs_ext_clk_src

/* tb/lcs_clock_cfg_tb.sv */
// Self-checking bench for the LCD clock source and command block
`timescale 1ns/1ps
`include "lcs_defines.svh"
module lcs_clock_cfg_tb
  import lcs_pkg::*;
;
  // ****************************************************************
  // Wiring
  // ****************************************************************
  localparam int OSC_DIV = `LCS_CLK_HZ / `LCS_OSC_HZ;
  localparam int EXT_CYC = 20;
  logic clk, rst, rst_n, rd, wr, pin_in, float_pat, ext_en, ext_drv;
  logic ext_lvl, waitreq, pin_out, pin_oe, osc_run, pd, hold;
  logic frame_tick, pwm_tick;
  logic [1:0] addr, mux, bias;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [11:0] pin_mode;
  logic [7:0] bad [4] = '{8'h0B, 8'h15, 8'h5A, 8'hF3};
  logic [31:0] exp_q [$];
  int num_errors = 0;
  int compares = 0;
  lcs_cfg_t mdl;

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Undriven pin shows a changing pattern, never a held value
  always @(posedge clk) float_pat <= (float_pat === 1'b1) ? 1'b0 : 1'b1;
  assign pin_in = pin_oe ? pin_out : (ext_drv ? ext_lvl : float_pat);

  lcs_clock_cfg u_lcs_clock_cfg (.I_CLOCK(clk), .I_SYS_RST(rst),
    .I_RESET_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_SHARED_CLOCK_PIN(pin_in), .O_SHARED_CLOCK_PIN(pin_out),
    .O_SHARED_CLOCK_PIN_OE(pin_oe), .O_OSC_RUN(osc_run),
    .O_LCD_FRAME_TICK(frame_tick), .O_PWM_CLK_TICK(pwm_tick),
    .O_PIN_MODE_FIELD(pin_mode), .O_MUX_MODE(mux), .O_BIAS_MODE(bias));

  lcs_ext_clk_src #(.HALF_NS(EXT_CYC * 12.5)) u_lcs_ext_clk_src (
    .i_enable(ext_en), .o_drive(ext_drv), .o_level(ext_lvl));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic r, input logic [1:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    rd <= r;
    wr <= ~r;
    addr <= a;
    wdata <= d;
    be <= b;
    // Waitrequest is sampled at the rising edge, before that edge updates
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      num_errors++;
      print_verdict();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Command write; the model follows the documented decoding
  task automatic send(input logic [7:0] c);
    logic [31:0] r;
    r = $urandom;
    bus(1'b0, 2'h0, {r[31:8], c}, 4'hF);
    if (c[7:2] == 6'h00) mdl.mux_mode = c[1:0];
    else if (c[7:2] == 6'h01) mdl.bias_mode = c[1:0];
    else if (c[7:3] == 5'h03)
      {mdl.ext_freq_range, mdl.clock_out_enable, mdl.osc_source} = c[2:0];
    else if (c[7:5] == 3'h1) mdl.lcd_frame_prescaler = c[4:0];
    else if (c[7:4] >= 4'hC && c[7:4] <= 4'hE)
      mdl.pin_mode_field[4 * (c[7:4] - 12) +: 4] = c[3:0];
    repeat (4) @(posedge clk);
  endtask : send

  task automatic check_all();
    logic oe, run, pwm;
    pwm = 1'b0;
    for (int k = 0; k < 6; k++) pwm |= &mdl.pin_mode_field[2 * k +: 2];
    oe = mdl.clock_out_enable & ~mdl.osc_source & ~hold;
    run = ~pd & ~hold & (~mdl.osc_source | (pwm & ~mdl.ext_freq_range));
    check("pin_mode", 32'(mdl.pin_mode_field), 32'(pin_mode));
    check("mux", 32'(mdl.mux_mode), 32'(mux));
    check("bias", 32'(mdl.bias_mode), 32'(bias));
    check("clock_pin_oe", 32'(oe), 32'(pin_oe));
    check("osc_run", 32'(run), 32'(osc_run));
    exp_q.push_back({5'h00, oe, run, pd, mdl});
    bus(1'b1, 2'h2, 32'h0000_0000, 4'hF);
  endtask : check_all

  // Cycles between two rising edges, and high cycles in that span
  task automatic measure(input logic [1:0] sel, output int per,
                         output int hi);
    logic s, p;
    int n;
    per = 0;
    hi = 1;
    n = 0;
    p = 1'b1;
    for (int ph = 0; ph < 2; ph++) begin
      while (n < 40000) begin
        @(negedge clk);
        s = (sel == 2'h2) ? pwm_tick : ((sel == 2'h1) ? frame_tick : pin_out);
        n++;
        if (ph == 1) per++;
        if (s === 1'b1 && p === 1'b0) break;
        if (ph == 1 && s === 1'b1) hi++;
        p = s;
      end
      p = 1'b1;
    end
  endtask : measure

  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Read answers are compared with the oldest queued note
  always @(negedge clk) begin
    if (rd === 1'b1 && waitreq === 1'b0) begin
      if (exp_q.size() == 0) num_errors++;
      else check("readdata", exp_q.pop_front(), rdata);
    end
  end

  // Watchdog sized above the longest measured frame spans
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    int per, hi;
    {rst, rst_n, rd, wr, addr, wdata, be} = {2'b11, 40'h00_0000_0000};
    {ext_en, pd, hold} = 3'h0;
    mdl = '0;
    mdl.lcd_frame_prescaler = 5'h0E;
    void'($urandom(12));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    check_all();
    // Refused accesses: unmapped place, and lane 0 disabled
    bus(1'b0, 2'h3, 32'h0000_0003, 4'hF);
    exp_q.push_back(32'h0000_0000);
    bus(1'b1, 2'h3, 32'h0000_0000, 4'hF);
    bus(1'b0, 2'h0, 32'h0000_0003, 4'hE);
    check_all();
    for (int m = 0; m < 8; m++) begin
      send(8'(m));
      check_all();
    end
    for (int k = 0; k < 6; k++) begin
      send({4'(12 + k % 3), k < 3 ? 4'($urandom) : 4'h0});
      check_all();
    end
    foreach (bad[i]) begin
      send(bad[i]);
      check_all();
    end
    // Internal clock on the pin, two divide ratios
    send(8'h1A);
    check_all();
    measure(2'h0, per, hi);
    check("pin_period", 32'(OSC_DIV * 24), 32'(per));
    check("pin_high", 32'(OSC_DIV * 12), 32'(hi));
    measure(2'h2, per, hi);
    check("pwm_period", 32'(OSC_DIV), 32'(per));
    check("pwm_high", 32'h1, 32'(hi));
    send(8'h2D);
    measure(2'h0, per, hi);
    check("pin_period", 32'(OSC_DIV * 25), 32'(per));
    check("pin_high", 32'(OSC_DIV * 12), 32'(hi));
    send(8'h2E);
    // Power-down with output enabled drives the pin high
    bus(1'b0, 2'h1, 32'h0000_0001, 4'hF);
    pd = 1'b1;
    repeat (4) @(posedge clk);
    check_all();
    check("pin_level", 32'h1, 32'(pin_out));
    bus(1'b0, 2'h1, 32'h0000_0000, 4'hF);
    pd = 1'b0;
    // External clock, low range then high range
    send(8'h1B);
    ext_en <= 1'b1;
    check_all();
    measure(2'h1, per, hi);
    check("frame_period", 32'(48 * EXT_CYC), 32'(per));
    send(8'hC3);
    check_all();
    send(8'h1F);
    send(8'h36);
    check_all();
    measure(2'h1, per, hi);
    check("frame_period", 32'(48 * 16 * EXT_CYC), 32'(per));
    measure(2'h2, per, hi);
    check("pwm_period", 32'(EXT_CYC), 32'(per));
    // Device reset pin
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    hold = 1'b1;
    mdl = '0;
    mdl.lcd_frame_prescaler = 5'h0E;
    check_all();
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    hold = 1'b0;
    check_all();
    print_verdict();
  end
endmodule : lcs_clock_cfg_tb
